/* common/ncf_pkg.sv */
// Shared constants and types of the network command and filter block.
// Assumes one 25 MHz controller clock; function codes are octal values, status codes hex values.
package ncf_pkg;

	// Function codes taken from the command field.
	localparam logic [5:0] FC_DIAG       = 6'h0a;
	localparam logic [5:0] FC_DEF_ADDR   = 6'h0f;
	localparam logic [5:0] FC_MC_ALL_SET = 6'h10;
	localparam logic [5:0] FC_MC_ALL_CLR = 6'h11;
	localparam logic [5:0] FC_LOOP_TEST  = 6'h12;
	localparam logic [5:0] FC_COL_TEST   = 6'h13;
	localparam logic [5:0] FC_RSV_LO     = 6'h14;
	localparam logic [5:0] FC_RSV_HI     = 6'h17;
	localparam logic [5:0] FC_STATS      = 6'h18;
	localparam logic [5:0] FC_RESET      = 6'h3f;

	// Completion status codes.
	localparam logic [3:0] SC_OK         = 4'h0;
	localparam logic [3:0] SC_RETRY      = 4'h1;
	localparam logic [3:0] SC_ILLEGAL    = 4'h2;
	localparam logic [3:0] SC_INAPPROP   = 4'h3;
	localparam logic [3:0] SC_JABBER     = 4'h4;
	localparam logic [3:0] SC_CARRIER    = 4'h5;
	localparam logic [3:0] SC_EXCESS     = 4'h8;
	localparam logic [3:0] SC_NO_HB      = 4'hb;
	localparam logic [3:0] SC_CRC_MISSED = 4'hc;
	localparam logic [3:0] SC_DATA_ERR   = 4'hd;
	localparam logic [3:0] SC_CRC_FALSE  = 4'he;
	localparam logic [3:0] SC_NXM        = 4'hf;

	// Transmit outcome codes reported by the transmitter.
	localparam logic [2:0] TXR_OK      = 3'h0;
	localparam logic [2:0] TXR_RETRY   = 3'h1;
	localparam logic [2:0] TXR_JABBER  = 3'h2;
	localparam logic [2:0] TXR_CARRIER = 3'h3;
	localparam logic [2:0] TXR_EXCESS  = 3'h4;

	// Group table and statistics layout.
	localparam int          MC_ENTRIES = 63;
	localparam int          STAT_NUM   = 11;
	localparam logic [5:0]  STAT_WORDS = 6'h21;
	localparam logic [15:0] STAT_LEN   = 16'h003e;
	localparam logic [5:0]  W_LEN      = 6'h01;
	localparam logic [5:0]  W_PHYS     = 6'h02;
	localparam logic [5:0]  W_RXCNT    = 6'h05;
	localparam logic [5:0]  W_FIFO     = 6'h06;
	localparam logic [5:0]  W_CNT1     = 6'h07;
	localparam logic [5:0]  W_RSV      = 6'h11;
	localparam logic [5:0]  W_MOD      = 6'h19;
	localparam logic [5:0]  W_FW       = 6'h1d;
	// Identification strings; the values are arbitrary.
	localparam logic [63:0] MODULE_ID   = 64'h4e_43_46_20_20_20_20_00;
	localparam logic [63:0] FIRMWARE_ID = 64'h56_30_2e_30_20_20_20_00;

	// Heartbeat timing.
	localparam int         CLK_PERIOD_NS = 40;
	localparam int         HB_EXPECT_NS  = 1000;
	localparam int         HB_WIN_NS     = 2 * HB_EXPECT_NS;
	localparam logic [6:0] HB_WIN_CYC    = 7'(HB_WIN_NS / CLK_PERIOD_NS);

	// Last byte of each loopback frame.
	localparam logic [7:0] LB_LAST0 = 8'ha5;
	localparam logic [7:0] LB_LAST1 = 8'h5a;

	typedef enum logic [2:0] {
		S_IDLE, S_LB_TX, S_LB_RX, S_CD_TX, S_CD_HB, S_DMA
	} ncf_state_e;

endpackage : ncf_pkg

/* hdl/ncf_mcast_filter.sv */
// Group address recognition table with hash prefilter and byte compare.
// Assumes table writes come from the address load path outside this block.
`timescale 1ns/1ps
module ncf_mcast_filter (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rst,
	// Table write port.
	input  wire logic        tbl_wr,
	input  wire logic [5:0]  tbl_idx,
	input  wire logic [47:0] tbl_addr,
	input  wire logic        tbl_valid,
	// Lookup.
	input  wire logic [47:0] da,
	output logic             hit
);

	// Folds a 48-bit address to a 6-bit hash.
	function automatic logic [5:0] hash6(input logic [47:0] a);
		logic [5:0] h;
		h = 6'h00;
		for (int i = 0; i < 8; i++) begin
			h = h ^ a[i*6 +: 6];
		end
		return h;
	endfunction : hash6

	logic [ncf_pkg::MC_ENTRIES-1:0] match;
	logic [5:0]                     da_hash;

	assign da_hash = hash6(da);

	// One entry per table slot, each with its stored hash.
	for (genvar g = 0; g < ncf_pkg::MC_ENTRIES; g++) begin : g_ent
		logic [47:0] addr_q, addr_d;
		logic [5:0]  hash_q, hash_d;
		logic        vld_q, vld_d;
		logic [5:0]  byte_eq;
		// Next values of the slot.
		always_comb begin
			addr_d = addr_q;
			hash_d = hash_q;
			vld_d  = vld_q;
			if (tbl_wr && tbl_idx == 6'(g)) begin
				addr_d = tbl_addr;
				hash_d = hash6(tbl_addr);
				vld_d  = tbl_valid;
			end
		end
		// Slot registers.
		always_ff @(posedge clk) begin
			if (rst) begin
				addr_q <= 48'h0;
				hash_q <= 6'h00;
				vld_q  <= 1'b0;
			end else begin
				addr_q <= addr_d;
				hash_q <= hash_d;
				vld_q  <= vld_d;
			end
		end
		// Hash first, then each byte.
		for (genvar b = 0; b < 6; b++) begin : g_byte
			assign byte_eq[b] = (addr_q[b*8 +: 8] == da[b*8 +: 8]);
		end
		assign match[g] = vld_q && (hash_q == da_hash) && (&byte_eq);
	end

	assign hit = |match;

endmodule : ncf_mcast_filter

/* hdl/ncf_cmd_ctrl.sv */
// Command handler: modes, self-tests, statistics DMA.
// Assumes transmitter, receiver and DMA engine on CLK_SYS.
//
// Functional notes
// - Code enters field 13..8; status returns in field 3..0.
// - Code 17 selects factory address, status 00.
// - Factory address: unmatched unicast never reaches the FIFO.
// - Power-up, 77 and 12 restore factory address and hash filtering.
// - Statistics report the factory address once selected.
// - Code 20 accepts all multicast, bypassing the table.
// - All-multicast frames: network when online, host when looped.
// - Code 21 filters multicast by hash, then byte compare.
// - Group table holds at most 63 entries.
// - Loopback sends two short self frames, bad then good CRC.
// - Loopback checks each CRC result and the last byte.
// - Loopback reports 00 clean, 01 retried, 03 offline.
// - Loopback reports 04 on jabber, 05 on carrier failure.
// - Loopback reports 08 after sixteen collided attempts.
// - Loopback reports 0C, 0D, 0E for CRC and data faults.
// - Collision test sends one frame, awaits heartbeat near 1 us.
// - Collision test reports 00 on heartbeat, 0B without.
// - Codes 24 to 27 are reserved and answer 02.
// - Code 30 sends statistics by DMA, then clears counters.
// - Counters are unsigned 16 bits and wrap silently.
// - DMA fault aborts with status 0F.
// - Reset 77 and power-up clear counters except FIFO count.
`timescale 1ns/1ps
module ncf_cmd_ctrl (
	// Clock and reset.
	input  wire logic                          CLK_SYS,
	input  wire logic                          SYS_RST,
	// Command write into the command/status register.
	input  wire logic                          CMD_WR,
	input  wire logic [5:0]                    CMD_CODE,
	input  wire logic [1:0]                    CMD_ADDR_HI,
	input  wire logic [15:0]                   BUF_ADDR_LO,
	input  wire logic [15:0]                   DMA_BYTE_COUNT,
	output logic [3:0]                         CMD_STATUS,
	output logic                               CMD_BUSY,
	output logic                               CMD_DONE,
	// Addresses and link mode.
	input  wire logic [47:0]                   FACTORY_ADDR,
	input  wire logic [47:0]                   USER_ADDR,
	input  wire logic                          ONLINE,
	input  wire logic                          INT_LOOPBACK,
	output logic                               USE_FACTORY,
	output logic                               ALL_MCAST,
	// Group table write port.
	input  wire logic                          TBL_WR,
	input  wire logic [5:0]                    TBL_IDX,
	input  wire logic [47:0]                   TBL_ADDR,
	input  wire logic                          TBL_VALID,
	// Receive address filter.
	input  wire logic                          RX_DA_VALID,
	input  wire logic [47:0]                   RX_DA,
	input  wire logic                          RX_FROM_HOST,
	output logic                               RX_ACCEPT,
	output logic                               RX_DROP,
	// Self-test transmit and receive.
	output logic                               TX_START,
	output logic                               TX_BAD_CRC,
	output logic [47:0]                        TX_DEST,
	output logic [7:0]                         TX_LAST_BYTE,
	input  wire logic                          TX_DONE,
	input  wire logic [2:0]                    TX_RESULT,
	input  wire logic                          RX_DONE,
	input  wire logic                          RX_CRC_ERR,
	input  wire logic [7:0]                    RX_LAST_BYTE,
	input  wire logic                          COL_HEARTBEAT,
	// Statistics events and DMA master.
	input  wire logic [ncf_pkg::STAT_NUM-1:0]  STAT_EVENT,
	input  wire logic [15:0]                   RX_FIFO_FRAMES,
	output logic                               DMA_REQ,
	output logic [17:0]                        DMA_ADDR,
	output logic [15:0]                        DMA_DATA,
	input  wire logic                          DMA_ACK,
	input  wire logic                          DMA_ERR
);

	ncf_pkg::ncf_state_e st_q, st_d;
	logic [3:0]  status_q, status_d;
	logic        done_q, done_d;
	logic        use_fact_q, use_fact_d;
	logic        all_mc_q, all_mc_d;
	logic        second_q, second_d;
	logic        retried_q, retried_d;
	logic [6:0]  hb_cnt_q, hb_cnt_d;
	logic [5:0]  widx_q, widx_d;
	logic [17:0] base_q, base_d;
	logic [15:0] ddata_q, ddata_d;
	logic        txs_q, txs_d;
	logic        acc_q, acc_d, drop_q, drop_d;
	logic        cnt_clr;
	logic        mc_hit;
	logic [47:0] phys;
	logic [15:0] cnt_q [ncf_pkg::STAT_NUM];

	// Current physical address follows the selected source.
	assign phys = use_fact_q ? FACTORY_ADDR : USER_ADDR;

	// Selects one 16-bit word of the statistics buffer.
	function automatic logic [15:0] stat_word(input logic [5:0] w);
		logic [15:0] r;
		r = 16'h0000;
		if (w == ncf_pkg::W_LEN) begin
			r = ncf_pkg::STAT_LEN;
		end else if (w >= ncf_pkg::W_PHYS && w < ncf_pkg::W_RXCNT) begin
			r = {phys[6'(39 - 16*int'(w - ncf_pkg::W_PHYS)) -: 8],
				phys[6'(47 - 16*int'(w - ncf_pkg::W_PHYS)) -: 8]};
		end else if (w == ncf_pkg::W_RXCNT) begin
			r = cnt_q[0];
		end else if (w == ncf_pkg::W_FIFO) begin
			r = RX_FIFO_FRAMES;
		end else if (w >= ncf_pkg::W_CNT1 && w < ncf_pkg::W_RSV) begin
			r = cnt_q[4'(w - ncf_pkg::W_CNT1) + 4'h1];
		end else if (w >= ncf_pkg::W_MOD && w < ncf_pkg::W_FW) begin
			r = {ncf_pkg::MODULE_ID[7'(55 - 16*int'(w - ncf_pkg::W_MOD)) -: 8],
				ncf_pkg::MODULE_ID[7'(63 - 16*int'(w - ncf_pkg::W_MOD)) -: 8]};
		end else if (w >= ncf_pkg::W_FW && w < ncf_pkg::STAT_WORDS) begin
			r = {ncf_pkg::FIRMWARE_ID[7'(55 - 16*int'(w - ncf_pkg::W_FW)) -: 8],
				ncf_pkg::FIRMWARE_ID[7'(63 - 16*int'(w - ncf_pkg::W_FW)) -: 8]};
		end
		return r;
	endfunction : stat_word

	// Group address table with its hash prefilter.
	ncf_mcast_filter u_mcast (
		.clk       (CLK_SYS),
		.rst       (SYS_RST),
		.tbl_wr    (TBL_WR),
		.tbl_idx   (TBL_IDX),
		.tbl_addr  (TBL_ADDR),
		.tbl_valid (TBL_VALID && TBL_IDX < 6'(ncf_pkg::MC_ENTRIES)),
		.da        (RX_DA),
		.hit       (mc_hit)
	);

	// Command sequencer next state.
	always_comb begin
		st_d      = st_q;
		status_d  = status_q;
		done_d    = 1'b0;
		use_fact_d = use_fact_q;
		all_mc_d  = all_mc_q;
		second_d  = second_q;
		retried_d = retried_q;
		hb_cnt_d  = hb_cnt_q;
		widx_d    = widx_q;
		base_d    = base_q;
		ddata_d   = ddata_q;
		txs_d     = 1'b0;
		cnt_clr   = 1'b0;
		case (st_q)
			ncf_pkg::S_IDLE: begin
				if (CMD_WR) begin
					done_d   = 1'b1;
					status_d = ncf_pkg::SC_OK;
					case (CMD_CODE)
						ncf_pkg::FC_DEF_ADDR: use_fact_d = 1'b1;
						ncf_pkg::FC_MC_ALL_SET: all_mc_d = 1'b1;
						ncf_pkg::FC_MC_ALL_CLR: all_mc_d = 1'b0;
						ncf_pkg::FC_RESET, ncf_pkg::FC_DIAG: begin
							use_fact_d = 1'b1;
							all_mc_d   = 1'b0;
							cnt_clr    = (CMD_CODE == ncf_pkg::FC_RESET);
						end
						ncf_pkg::FC_LOOP_TEST, ncf_pkg::FC_COL_TEST: begin
							if (!ONLINE) begin
								status_d = ncf_pkg::SC_INAPPROP;
							end else begin
								done_d    = 1'b0;
								txs_d     = 1'b1;
								second_d  = 1'b0;
								retried_d = 1'b0;
								st_d = (CMD_CODE == ncf_pkg::FC_LOOP_TEST) ?
									ncf_pkg::S_LB_TX : ncf_pkg::S_CD_TX;
							end
						end
						ncf_pkg::FC_STATS: begin
							done_d  = 1'b0;
							widx_d  = 6'h00;
							base_d  = {CMD_ADDR_HI, BUF_ADDR_LO};
							ddata_d = stat_word(6'h00);
							st_d    = ncf_pkg::S_DMA;
						end
						default: begin
							if (CMD_CODE >= ncf_pkg::FC_RSV_LO && CMD_CODE <= ncf_pkg::FC_RSV_HI)
								status_d = ncf_pkg::SC_ILLEGAL;
						end
					endcase
				end
			end
			ncf_pkg::S_LB_TX: begin
				if (TX_DONE) begin
					st_d   = ncf_pkg::S_IDLE;
					done_d = 1'b1;
					case (TX_RESULT)
						ncf_pkg::TXR_JABBER: status_d = ncf_pkg::SC_JABBER;
						ncf_pkg::TXR_CARRIER: status_d = ncf_pkg::SC_CARRIER;
						ncf_pkg::TXR_EXCESS: status_d = ncf_pkg::SC_EXCESS;
						default: begin
							done_d    = 1'b0;
							retried_d = retried_q || (TX_RESULT == ncf_pkg::TXR_RETRY);
							st_d      = ncf_pkg::S_LB_RX;
						end
					endcase
				end
			end
			ncf_pkg::S_LB_RX: begin
				if (RX_DONE) begin
					st_d   = ncf_pkg::S_IDLE;
					done_d = 1'b1;
					if (!second_q && !RX_CRC_ERR) begin
						status_d = ncf_pkg::SC_CRC_MISSED;
					end else if (second_q && RX_CRC_ERR) begin
						status_d = ncf_pkg::SC_CRC_FALSE;
					end else if (RX_LAST_BYTE != TX_LAST_BYTE) begin
						status_d = ncf_pkg::SC_DATA_ERR;
					end else if (!second_q) begin
						done_d   = 1'b0;
						second_d = 1'b1;
						txs_d    = 1'b1;
						st_d     = ncf_pkg::S_LB_TX;
					end else begin
						status_d = retried_q ? ncf_pkg::SC_RETRY : ncf_pkg::SC_OK;
					end
				end
			end
			ncf_pkg::S_CD_TX: begin
				hb_cnt_d = 7'h00;
				if (TX_DONE)
					st_d = ncf_pkg::S_CD_HB;
			end
			ncf_pkg::S_CD_HB: begin
				hb_cnt_d = hb_cnt_q + 7'h01;
				if (COL_HEARTBEAT || hb_cnt_q >= ncf_pkg::HB_WIN_CYC) begin
					st_d     = ncf_pkg::S_IDLE;
					done_d   = 1'b1;
					status_d = COL_HEARTBEAT ? ncf_pkg::SC_OK : ncf_pkg::SC_NO_HB;
				end
			end
			ncf_pkg::S_DMA: begin
				if (DMA_ERR) begin
					st_d     = ncf_pkg::S_IDLE;
					done_d   = 1'b1;
					status_d = ncf_pkg::SC_NXM;
				end else if (DMA_ACK) begin
					widx_d  = widx_q + 6'h01;
					ddata_d = stat_word(widx_q + 6'h01);
					if (widx_q == ncf_pkg::STAT_WORDS - 6'h01) begin
						st_d     = ncf_pkg::S_IDLE;
						done_d   = 1'b1;
						status_d = ncf_pkg::SC_OK;
						cnt_clr  = 1'b1;
					end
				end
			end
			default: st_d = ncf_pkg::S_IDLE;
		endcase
	end

	// Receive filter decision for each presented destination address.
	always_comb begin
		acc_d  = 1'b0;
		drop_d = 1'b0;
		if (RX_DA_VALID) begin
			if (&RX_DA) begin
				acc_d = 1'b1;
			end else if (RX_DA[40]) begin
				acc_d = (all_mc_q ? (RX_FROM_HOST ? INT_LOOPBACK : ONLINE)
					: mc_hit);
			end else begin
				acc_d = (RX_DA == phys);
			end
			drop_d = !acc_d;
		end
	end

	// Sequencer and filter registers.
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			st_q       <= ncf_pkg::S_IDLE;
			status_q   <= ncf_pkg::SC_OK;
			done_q     <= 1'b0;
			use_fact_q <= 1'b1;
			all_mc_q   <= 1'b0;
			second_q   <= 1'b0;
			retried_q  <= 1'b0;
			hb_cnt_q   <= 7'h00;
			widx_q     <= 6'h00;
			base_q     <= 18'h0;
			ddata_q    <= 16'h0000;
			txs_q      <= 1'b0;
			acc_q      <= 1'b0;
			drop_q     <= 1'b0;
		end else begin
			st_q       <= st_d;
			status_q   <= status_d;
			done_q     <= done_d;
			use_fact_q <= use_fact_d;
			all_mc_q   <= all_mc_d;
			second_q   <= second_d;
			retried_q  <= retried_d;
			hb_cnt_q   <= hb_cnt_d;
			widx_q     <= widx_d;
			base_q     <= base_d;
			ddata_q    <= ddata_d;
			txs_q      <= txs_d;
			acc_q      <= acc_d;
			drop_q     <= drop_d;
		end
	end

	// Statistics counters; an event in the clearing cycle still counts.
	for (genvar g = 0; g < ncf_pkg::STAT_NUM; g++) begin : g_cnt
		logic [15:0] c_d;
		always_comb begin
			c_d = cnt_clr ? 16'h0000 : cnt_q[g];
			c_d = c_d + {15'h0000, STAT_EVENT[g]};
		end
		always_ff @(posedge CLK_SYS) begin
			if (SYS_RST)
				cnt_q[g] <= 16'h0000;
			else
				cnt_q[g] <= c_d;
		end
	end

	// Port drive.
	assign CMD_STATUS   = status_q;
	assign CMD_BUSY     = (st_q != ncf_pkg::S_IDLE);
	assign CMD_DONE     = done_q;
	assign USE_FACTORY  = use_fact_q;
	assign ALL_MCAST    = all_mc_q;
	assign RX_ACCEPT    = acc_q;
	assign RX_DROP      = drop_q;
	assign TX_START     = txs_q;
	assign TX_BAD_CRC   = !second_q;
	assign TX_DEST      = phys;
	assign TX_LAST_BYTE = second_q ? ncf_pkg::LB_LAST1 : ncf_pkg::LB_LAST0;
	assign DMA_REQ      = (st_q == ncf_pkg::S_DMA);
	assign DMA_ADDR     = base_q + {11'h000, widx_q, 1'b0};
	assign DMA_DATA     = ddata_q;

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (SYS_RST);

	a_def_addr_sel: assert property (CMD_WR && !CMD_BUSY && CMD_CODE == ncf_pkg::FC_DEF_ADDR
		|=> USE_FACTORY && CMD_DONE && CMD_STATUS == ncf_pkg::SC_OK)
		else $error("factory address select failed");
	a_rsv_illegal: assert property (CMD_WR && !CMD_BUSY && CMD_CODE >= ncf_pkg::FC_RSV_LO
		&& CMD_CODE <= ncf_pkg::FC_RSV_HI |=> CMD_STATUS == ncf_pkg::SC_ILLEGAL)
		else $error("reserved code not illegal");
	a_mc_all_mode: assert property (CMD_WR && !CMD_BUSY && CMD_CODE == ncf_pkg::FC_MC_ALL_SET
		|=> ALL_MCAST)
		else $error("all multicast not set");
	a_unicast_drop: assert property (RX_DA_VALID && !RX_DA[40] && RX_DA != phys
		|=> RX_DROP && !RX_ACCEPT)
		else $error("foreign unicast accepted");
	a_offline_test: assert property (CMD_WR && !CMD_BUSY && !ONLINE
		&& CMD_CODE == ncf_pkg::FC_LOOP_TEST |=> !CMD_BUSY && CMD_STATUS == ncf_pkg::SC_INAPPROP)
		else $error("offline loopback not refused");
	a_hb_bounded: assert property ($rose(st_q == ncf_pkg::S_CD_HB)
		|-> ##[1:52] CMD_DONE)
		else $error("heartbeat wait unbounded");
	a_dma_abort: assert property (DMA_REQ && DMA_ERR
		|=> CMD_DONE && CMD_STATUS == ncf_pkg::SC_NXM && !DMA_REQ)
		else $error("dma error not aborted");
	a_status_stable: assert property (CMD_BUSY && !CMD_DONE ##1 CMD_BUSY
		|-> $stable(CMD_STATUS))
		else $error("status changed mid command");
	a_stats_clear: assert property (DMA_REQ && DMA_ACK && !DMA_ERR
		&& widx_q == ncf_pkg::STAT_WORDS - 6'h01 && !STAT_EVENT[0] |=> cnt_q[0] == 16'h0000)
		else $error("counters not cleared");
	a_bad_crc_first: assert property (TX_START && $past(st_q == ncf_pkg::S_IDLE)
		|-> TX_BAD_CRC && TX_LAST_BYTE == ncf_pkg::LB_LAST0)
		else $error("first frame crc not corrupted");
	c_loop_ok: cover property (st_q == ncf_pkg::S_LB_RX && second_q && RX_DONE ##1
		CMD_STATUS == ncf_pkg::SC_OK);
	c_hb_seen: cover property (st_q == ncf_pkg::S_CD_HB && COL_HEARTBEAT);
	c_stats_done: cover property (DMA_REQ && DMA_ACK ##1 !DMA_REQ && CMD_DONE);
	c_mc_hit: cover property (RX_DA_VALID && RX_DA[40] && mc_hit);

endmodule : ncf_cmd_ctrl

/* test/ncf_far_model.sv */
// Far side model: transmitter, receiver, heartbeat and DMA target.
// Assumes the bench sets the knobs before each command.
`timescale 1ns/1ps
module ncf_far_model (
	// Clock and reset.
	input  wire logic       clk,
	input  wire logic       rst,
	// Knobs from the bench.
	input  wire logic [2:0] k_res,
	input  wire logic [1:0] k_flip,
	input  wire logic       k_byte,
	input  wire logic       k_hb,
	input  wire logic       k_err,
	input  wire logic       k_slow,
	// Self-test frame link.
	input  wire logic       tx_start,
	input  wire logic       tx_bad_crc,
	input  wire logic [7:0] tx_last,
	output logic            tx_done,
	output logic [2:0]      tx_result,
	output logic            rx_done,
	output logic            rx_crc_err,
	output logic [7:0]      rx_last,
	output logic            col_hb,
	// Host memory target.
	input  wire logic       dma_req,
	output logic            dma_ack,
	output logic            dma_err
);
	logic       bad;
	logic [7:0] lst;
	int         n;

	// Sends each frame, then raises the heartbeat when k_hb is set, or else echoes it when the outcome is ok or retry.
	initial begin
		{tx_done, rx_done, col_hb, rx_crc_err} = 4'h0;
		tx_result = 3'h0;
		rx_last = 8'h00;
		forever begin
			@(posedge clk);
			if (!rst && tx_start) begin
				bad = tx_bad_crc;
				lst = tx_last;
				repeat (k_slow ? 20 : 3) @(posedge clk);
				tx_done <= 1'b1;
				tx_result <= k_res;
				@(posedge clk);
				tx_done <= 1'b0;
				tx_result <= ~k_res; // The outcome is not left standing.
				if (k_hb) begin
					repeat (25) @(posedge clk);
					col_hb <= 1'b1;
					@(posedge clk);
					col_hb <= 1'b0;
				end else if (k_res < 3'h2) begin
					@(posedge clk);
					rx_done <= 1'b1;
					rx_crc_err <= bad ? !k_flip[0] : k_flip[1];
					rx_last <= lst ^ {7'h00, k_byte};
					@(posedge clk);
					rx_done <= 1'b0;
					rx_last <= ~rx_last; // Released bytes do not keep their value.
				end
			end
		end
	end

	// Acks each word, or aborts on the fifth when told to.
	initial begin
		{dma_ack, dma_err} = 2'h0;
		n = 0;
		forever begin
			@(posedge clk);
			if (rst || !dma_req) begin
				n = 0;
			end else begin
				repeat (k_slow ? 3 : 0) @(posedge clk);
				n = n + 1;
				if (k_err && n == 5) dma_err <= 1'b1;
				else dma_ack <= 1'b1;
				@(posedge clk);
				{dma_ack, dma_err} <= 2'h0;
			end
		end
	end
endmodule : ncf_far_model

/* test/test_net_ctrl_filter_test_stats_cmds.sv */
// Self-checking bench of the command handler.
// Assumes the far model answers frames and DMA.
`timescale 1ns/1ps
module test_net_ctrl_filter_test_stats_cmds;
	logic        clk, rst, cmd_wr, busy, done, online, lb, use_fac, all_mc, tbl_wr, tbl_v;
	logic        rx_v, rx_host, acc, drop, tx_start, tx_bad, tx_done, rx_done, rx_crc, hb;
	logic        dma_req, dma_ack, dma_err, k_byte, k_hb, k_err, k_slow, amc;
	logic [1:0]  hi, k_flip;
	logic [2:0]  tx_res, k_res;
	logic [3:0]  status;
	logic [5:0]  code, tbl_idx;
	logic [7:0]  tx_last, rx_last;
	logic [10:0] ev;
	logic [15:0] lo, dma_data, cnt[11];
	logic [15:0] fifo = 16'h0007;
	logic [17:0] dma_addr;
	logic [47:0] tbl_a, da, tx_dest, tbl[64];
	logic [47:0] fac = 48'h0a1b2c3d4e5f;
	logic [47:0] usr = 48'h0a1b2c3d4e60;
	logic        tv[64];
	logic [33:0] q[$];
	logic [31:0] seed = 32'h2571;
	logic [3:0]  lbx[9] = '{ncf_pkg::SC_OK, ncf_pkg::SC_RETRY, ncf_pkg::SC_JABBER,
		ncf_pkg::SC_CARRIER, ncf_pkg::SC_EXCESS, ncf_pkg::SC_CRC_MISSED,
		ncf_pkg::SC_CRC_FALSE, ncf_pkg::SC_DATA_ERR, ncf_pkg::SC_INAPPROP};
	int          n_fail = 0;
	int          checked = 0;
	int          cyc = 0;

	ncf_cmd_ctrl dut_u (.CLK_SYS(clk), .SYS_RST(rst), .CMD_WR(cmd_wr), .CMD_CODE(code),
		.CMD_ADDR_HI(hi), .BUF_ADDR_LO(lo), .DMA_BYTE_COUNT(16'h0042), .CMD_STATUS(status),
		.CMD_BUSY(busy), .CMD_DONE(done), .FACTORY_ADDR(fac), .USER_ADDR(usr), .ONLINE(online),
		.INT_LOOPBACK(lb), .USE_FACTORY(use_fac), .ALL_MCAST(all_mc), .TBL_WR(tbl_wr),
		.TBL_IDX(tbl_idx), .TBL_ADDR(tbl_a), .TBL_VALID(tbl_v), .RX_DA_VALID(rx_v), .RX_DA(da),
		.RX_FROM_HOST(rx_host), .RX_ACCEPT(acc), .RX_DROP(drop), .TX_START(tx_start),
		.TX_BAD_CRC(tx_bad), .TX_DEST(tx_dest), .TX_LAST_BYTE(tx_last), .TX_DONE(tx_done),
		.TX_RESULT(tx_res), .RX_DONE(rx_done), .RX_CRC_ERR(rx_crc), .RX_LAST_BYTE(rx_last),
		.COL_HEARTBEAT(hb), .STAT_EVENT(ev), .RX_FIFO_FRAMES(fifo), .DMA_REQ(dma_req),
		.DMA_ADDR(dma_addr), .DMA_DATA(dma_data), .DMA_ACK(dma_ack), .DMA_ERR(dma_err));
	ncf_far_model far_u (.clk(clk), .rst(rst), .k_res(k_res), .k_flip(k_flip), .k_byte(k_byte),
		.k_hb(k_hb), .k_err(k_err), .k_slow(k_slow), .tx_start(tx_start), .tx_bad_crc(tx_bad),
		.tx_last(tx_last), .tx_done(tx_done), .tx_result(tx_res), .rx_done(rx_done),
		.rx_crc_err(rx_crc), .rx_last(rx_last), .col_hb(hb), .dma_req(dma_req),
		.dma_ack(dma_ack), .dma_err(dma_err));

	// Clock, hang limit, DMA capture, frame checks.
	always #20 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_fail++;
			wrap_up();
		end
		if (dma_ack && dma_req) q.push_back({dma_addr, dma_data});
		if (tx_start && code == ncf_pkg::FC_LOOP_TEST) begin
			chk("tx_dest", tx_dest, fac);
			chk("tx_frame", {tx_bad, tx_last}, tx_bad ? 9'h1a5 : 9'h05a);
		end
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	function automatic logic hit(input logic [47:0] a);
		for (int i = 0; i < 63; i++) if (tv[i] && tbl[i] == a) return 1'b1;
		return 1'b0;
	endfunction : hit

	// Expected statistics word.
	function automatic logic [15:0] word(input int i);
		logic [63:0] id;
		int          k;
		id = i < 29 ? ncf_pkg::MODULE_ID : ncf_pkg::FIRMWARE_ID;
		k = (i - 25) % 4;
		if (i == 1) return 16'h003e;
		if (i >= 2 && i <= 4) return {fac[71-16*i -: 8], fac[79-16*i -: 8]};
		if (i == 5) return cnt[0];
		if (i == 6) return fifo;
		if (i >= 7 && i <= 16) return cnt[i-6];
		if (i >= 25) return {id[55-16*k -: 8], id[63-16*k -: 8]};
		return 16'h0000;
	endfunction : word

	task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// Issues a command; poke tries a second one while busy.
	task automatic cmd(input logic [5:0] c, input logic poke);
		int i;
		@(posedge clk);
		cmd_wr <= 1'b1;
		code <= c;
		@(posedge clk);
		cmd_wr <= 1'b0;
		for (i = 0; i < 400 && done !== 1'b1; i++) begin
			@(posedge clk);
			cmd_wr <= poke && i == 3;
			code <= poke ? ncf_pkg::FC_MC_ALL_SET : c;
		end
		chk("cmd_done", done, 1'b1);
	endtask : cmd

	task automatic twr(input logic [5:0] i, input logic [47:0] a, input logic v);
		@(posedge clk);
		{tbl_wr, tbl_idx, tbl_a, tbl_v} <= {1'b1, i, a, v};
		tbl[i] = a;
		tv[i] = v && i != 6'h3f;
		@(posedge clk);
		tbl_wr <= 1'b0;
	endtask : twr

	task automatic rx(input logic [47:0] a);
		logic e;
		@(posedge clk);
		rx_v <= 1'b1;
		da <= a;
		@(posedge clk);
		rx_v <= 1'b0;
		@(posedge clk);
		e = &a || (a[40] ? (amc ? (rx_host ? lb : online) : hit(a)) : a == fac);
		chk("rx_verdict", {acc, drop}, {e, !e});
	endtask : rx

	task automatic events(input int n);
		logic [31:0] r;
		repeat (n) begin
			@(posedge clk);
			r = rnd();
			ev <= r[10:0];
			for (int j = 0; j < 11; j++) cnt[j] += 16'(r[j]);
		end
		@(posedge clk);
		ev <= '0;
	endtask : events

	task automatic stats(input logic [17:0] base, input logic err);
		k_err <= err;
		{hi, lo} <= base;
		q.delete();
		cmd(ncf_pkg::FC_STATS, 1'b1);
		chk("stat_status", status, err ? ncf_pkg::SC_NXM : ncf_pkg::SC_OK);
		chk("busy_refused", all_mc, amc);
		if (!err) begin
			chk("stat_count", q.size(), 33);
			for (int i = 0; i < q.size(); i++) begin
				chk("stat_word", q[i], {base + 18'(2*i), word(i)});
			end
			foreach (cnt[j]) cnt[j] = 16'h0000;
		end
	endtask : stats

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : wrap_up

	// Main sequence.
	initial begin
		logic [31:0] r;
		clk = 1'b0;
		rst = 1'b1;
		{cmd_wr, tbl_wr, tbl_v, rx_v, rx_host, online, lb, k_byte, k_hb, k_err, k_slow} = '0;
		{code, hi, lo, tbl_idx, tbl_a, da, ev, k_res, k_flip} = '0;
		foreach (tv[i]) tv[i] = 1'b0;
		foreach (cnt[j]) cnt[j] = 16'h0000;
		amc = 1'b0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("reset_modes", {use_fac, all_mc, status}, 6'h20);
		for (int c = 20; c < 24; c++) begin
			cmd(6'(c), 1'b0);
			chk("reserved", status, ncf_pkg::SC_ILLEGAL);
		end
		cmd(ncf_pkg::FC_MC_ALL_SET, 1'b0);
		cmd(ncf_pkg::FC_DIAG, 1'b0);
		chk("diag_modes", {use_fac, all_mc}, 2'h2);
		cmd(ncf_pkg::FC_DEF_ADDR, 1'b0);
		chk("factory", {use_fac, status}, 5'h10);
		twr(6'h3e, {40'h01005e0000, 8'h01}, 1'b1);
		twr(6'h3f, {40'h01005e0000, 8'h02}, 1'b1);
		repeat (300) begin
			r = rnd();
			{rx_host, lb, online} <= r[2:0];
			if (r[7:4] == 4'h0) begin
				cmd(r[8] ? ncf_pkg::FC_MC_ALL_SET : ncf_pkg::FC_MC_ALL_CLR, 1'b0);
				amc = r[8];
				chk("all_mcast", all_mc, amc);
			end
			if (r[11:9] == 3'h0) twr(r[17:12], {40'h01005e0000, 5'h00, r[26:24]}, r[20]);
			case (r[23:21])
				3'h0: rx(48'hffffffffffff);
				3'h1: rx(fac);
				3'h2: rx(usr);
				3'h5: rx({rnd(), r[15:0]});
				default: rx({40'h01005e0000, 5'h00, r[26:24]});
			endcase
		end
		for (int i = 0; i < 9; i++) begin
			k_res <= i < 5 ? 3'(i) : 3'h0;
			k_flip <= i == 5 ? 2'h1 : (i == 6 ? 2'h2 : 2'h0);
			{k_byte, online, lb, k_slow} <= {i == 7, i != 8, 1'b0, i[0]};
			cmd(ncf_pkg::FC_LOOP_TEST, 1'b0);
			chk("loop_status", status, lbx[i]);
		end
		for (int i = 0; i < 3; i++) begin
			{k_res, k_byte, k_hb, online} <= {3'h0, 1'b0, i == 0, i != 2};
			cmd(ncf_pkg::FC_COL_TEST, 1'b0);
			chk("hb_status", status, i == 0 ? ncf_pkg::SC_OK :
				(i == 1 ? ncf_pkg::SC_NO_HB : ncf_pkg::SC_INAPPROP));
		end
		k_hb <= 1'b0;
		events(40);
		stats(18'h21234, 1'b1);
		k_slow <= 1'b1;
		stats(18'h2fe00, 1'b0);
		k_slow <= 1'b0;
		stats(18'h10000, 1'b0);
		events(30);
		cmd(ncf_pkg::FC_RESET, 1'b0);
		amc = 1'b0;
		foreach (cnt[j]) cnt[j] = 16'h0000;
		chk("reset_cmd", {use_fac, all_mc}, 2'h2);
		stats(18'h00100, 1'b0);
		wrap_up();
	end
endmodule : test_net_ctrl_filter_test_stats_cmds
